// File: shared/flash_lock_consts.svh
// constants for the flash lock-and-key guard
`ifndef FLASH_LOCK_CONSTS_SVH
`define FLASH_LOCK_CONSTS_SVH
`define FLK_KEY_FIRST 8'hA5
`define FLK_KEY_SECOND 8'hF1
`define FLK_RESET_VALUE 8'h00
`define FLK_STATE_LSB 0
`define FLK_STATE_MSB 1
`define FLK_CODE_LOCKED 2'h0
`define FLK_CODE_FIRST 2'h1
`define FLK_CODE_UNLOCKED 2'h2
`define FLK_CODE_DISABLED 2'h3
`define PSC_WRITE_ENABLE_BIT 0
`define PSC_ERASE_ENABLE_BIT 1
`endif

// File: shared/flash_lock_pkg.sv
// types for the flash lock-and-key guard
package flash_lock_pkg;
    typedef enum logic [1:0] {
        LK_LOCKED,
        LK_FIRST,
        LK_UNLOCKED,
        LK_DISABLED
    } lock_state_t;
    typedef enum logic [1:0] {
        OP_NONE,
        OP_WRITE,
        OP_ERASE
    } flash_op_t;
endpackage

// File: src/flash_op_decode.sv
// decodes an external-move write into a flash write or page erase request
`timescale 1ns/100ps
`default_nettype none
`include "flash_lock_consts.svh"
module flash_op_decode (
    input wire logic [7:0] program_store_control, // control register value
    input wire logic external_move_instruction_write, // external-move write strobe
    output var flash_lock_pkg::flash_op_t op // decoded operation
);
    import flash_lock_pkg::*;
    always_comb begin
        op = OP_NONE;
        if (external_move_instruction_write && program_store_control[`PSC_WRITE_ENABLE_BIT]) begin
            if (program_store_control[`PSC_ERASE_ENABLE_BIT]) begin
                op = OP_ERASE;
            end else begin
                op = OP_WRITE;
            end
        end
    end
endmodule // flash_op_decode
`default_nettype wire

// File: src/flash_lock_key_guard.sv
// flash lock-and-key guard with its program store control register
`timescale 1ns/100ps
`default_nettype none
`include "flash_lock_consts.svh"
module flash_lock_key_guard #(
    parameter int ADDR_W = 16, // flash address width
    parameter int PAGE_W = 9 // log2 of page size in bytes
) (
    input wire logic core_clk, // system clock, 125 MHz
    input wire logic resetn, // asynchronous device reset, active low
    input wire logic clk_en, // freezes all state while low
    input wire logic key_wr, // write strobe to flash_lock_key
    input wire logic [7:0] key_wdata, // data written to flash_lock_key
    output logic [7:0] flash_lock_key, // read value of flash_lock_key
    input wire logic ctl_wr, // write strobe to program_store_control
    input wire logic [7:0] ctl_wdata, // data written to program_store_control
    output logic [7:0] program_store_control, // read value of program_store_control
    input wire logic external_move_instruction_write, // external-move write strobe
    input wire logic [ADDR_W-1:0] external_move_instruction_addr, // external-move target address
    input wire logic [7:0] external_move_instruction_data, // external-move write data
    output logic flash_wr_req, // one-cycle byte program request
    output logic flash_erase_req, // one-cycle page erase request
    output logic [ADDR_W-1:0] flash_addr, // program address or page base
    output logic [7:0] flash_data, // byte to program
    input wire logic flash_done, // flash operation finished
    output logic flash_busy // an operation is under way
);
    import flash_lock_pkg::*;

    // a page must be smaller than the whole address space
    if (PAGE_W < 1 || PAGE_W >= ADDR_W) begin : g_page_chk
        $error("page width must be below address width");
    end

    ////////////////////////////////////////////////////////////////////////
    lock_state_t state_q;
    logic busy_q;
    logic [7:0] ctl_q;
    logic [7:0] wdata_q;
    logic [ADDR_W-1:0] addr_q;
    logic wr_q;
    logic er_q;
    flash_op_t op;

    flash_op_decode u_decode (
        .program_store_control(ctl_q),
        .external_move_instruction_write(external_move_instruction_write),
        .op(op)
    );

    ////////////////////////////////////////////////////////////////////////
    // lock state; attempts and key writes never coincide on one core, but
    // an attempt is checked first so a blocked one always disables
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= LK_LOCKED;
        end else if (clk_en) begin
            if (state_q == LK_DISABLED) begin
                state_q <= LK_DISABLED;
            end else if (op != OP_NONE && state_q != LK_UNLOCKED) begin
                state_q <= LK_DISABLED;
            end else if (busy_q && flash_done) begin
                state_q <= LK_LOCKED;
            end else if (key_wr) begin
                case (state_q)
                    LK_LOCKED: begin
                        if (key_wdata == `FLK_KEY_FIRST) begin
                            state_q <= LK_FIRST;
                        end else begin
                            state_q <= LK_DISABLED;
                        end
                    end
                    LK_FIRST: begin
                        if (key_wdata == `FLK_KEY_SECOND) begin
                            state_q <= LK_UNLOCKED;
                        end else begin
                            state_q <= LK_DISABLED;
                        end
                    end
                    // rewriting keys while unlocked breaks the sequence
                    LK_UNLOCKED: state_q <= LK_DISABLED;
                    default: state_q <= LK_DISABLED;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register: reserved bits held at zero
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctl_q <= `FLK_RESET_VALUE;
        end else if (clk_en && ctl_wr) begin
            ctl_q <= {6'h00, ctl_wdata[`PSC_ERASE_ENABLE_BIT], ctl_wdata[`PSC_WRITE_ENABLE_BIT]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // operation launch; only one attempt accepted per unlock
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            busy_q <= 1'b0;
            wr_q <= 1'b0;
            er_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= 8'h00;
        end else if (clk_en) begin
            wr_q <= 1'b0;
            er_q <= 1'b0;
            if (op != OP_NONE && state_q == LK_UNLOCKED && !busy_q) begin
                busy_q <= 1'b1;
                if (op == OP_ERASE) begin
                    er_q <= 1'b1;
                    addr_q <= {external_move_instruction_addr[ADDR_W-1:PAGE_W], {PAGE_W{1'b0}}};
                    wdata_q <= 8'h00;
                end else begin
                    wr_q <= 1'b1;
                    addr_q <= external_move_instruction_addr;
                    wdata_q <= external_move_instruction_data;
                end
            end else if (busy_q && flash_done) begin
                busy_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        flash_lock_key = 8'h00;
        flash_lock_key[`FLK_STATE_MSB:`FLK_STATE_LSB] = state_q;
    end

    assign program_store_control = ctl_q;
    assign flash_wr_req = wr_q;
    assign flash_erase_req = er_q;
    assign flash_addr = addr_q;
    assign flash_data = wdata_q;
    assign flash_busy = busy_q;
endmodule // flash_lock_key_guard
`default_nettype wire

// File: testbench/flash_lock_key_guard_asserts.sv
// port checker for the flash lock-and-key guard
`timescale 1ns/100ps
`default_nettype none
module flk_guard_chk #(parameter int ADDR_W = 16, parameter int PAGE_W = 9) (
    input wire logic core_clk, // clock
    input wire logic resetn, // reset
    input wire logic clk_en, // enable
    input wire logic key_wr, // key write
    input wire logic [7:0] key_wdata, // key data
    input wire logic [7:0] flash_lock_key, // state
    input wire logic [7:0] program_store_control, // control
    input wire logic external_move_instruction_write, // attempt
    input wire logic [ADDR_W-1:0] external_move_instruction_addr, // addr in
    input wire logic [7:0] external_move_instruction_data, // data in
    input wire logic flash_wr_req, // program
    input wire logic flash_erase_req, // erase
    input wire logic [ADDR_W-1:0] flash_addr, // addr out
    input wire logic [7:0] flash_data, // data out
    input wire logic flash_done, // done
    input wire logic flash_busy // busy
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    wire logic [1:0] st = flash_lock_key[1:0];
    wire logic go = clk_en && external_move_instruction_write && program_store_control[0];
    wire logic kw = clk_en && key_wr && !go && !(flash_done && flash_busy);
    wire logic ok1 = st == 2'h0 && key_wdata == 8'hA5;
    wire logic ok2 = st == 2'h1 && key_wdata == 8'hF1;
    wire logic run = clk_en && external_move_instruction_write && st == 2'h2 && !flash_busy;
    sequence unlock_s;
        kw && ok1 ##1 kw && ok2;
    endsequence
    first_key_a: assert property (kw && ok1 |=> st == 2'h1) else $error("first key lost");
    unlock_a: assert property (unlock_s |=> st == 2'h2) else $error("no unlock");
    bad_key_a: assert property (kw && st != 2'h3 && !ok1 && !ok2 |=> st == 2'h3) else $error("bad key");
    sticky_lock_a: assert property (st == 2'h3 |=> st == 2'h3) else $error("lock left");
    blocked_op_a: assert property (go && st != 2'h2 |=> st == 2'h3 && !flash_wr_req && !flash_erase_req)
        else $error("attempt passed");
    relock_a: assert property (clk_en && flash_done && flash_busy && st == 2'h2 |=> st == 2'h0 && !flash_busy)
        else $error("no relock");
    byte_prog_a: assert property (run && program_store_control[1:0] == 2'h1 |=> flash_wr_req && !flash_erase_req
        && flash_addr == $past(external_move_instruction_addr) && flash_data == $past(external_move_instruction_data)) else $error("program");
    page_erase_a: assert property (run && program_store_control[1:0] == 2'h3 |=> flash_erase_req && !flash_wr_req
        && flash_data == 8'h00 && flash_addr[PAGE_W-1:0] == '0) else $error("erase");
    read_code_a: assert property (flash_lock_key[7:2] == 6'h00) else $error("read bits");
endmodule // flk_guard_chk
bind flash_lock_key_guard flk_guard_chk #(.ADDR_W(ADDR_W), .PAGE_W(PAGE_W)) chk_u (.*);
`default_nettype wire

// File: testbench/flash_lock_key_guard_tb.sv
// directed and random bench for the flash lock-and-key guard
`timescale 1ns/100ps
`default_nettype none
module flash_lock_key_guard_tb;
    logic core_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, key_wr = 1'b0, ctl_wr = 1'b0, external_move_instruction_write = 1'b0;
    logic flash_done = 1'b0, flash_wr_req, flash_erase_req, flash_busy, bz, wr, er;
    logic [7:0] key_wdata = '0, ctl_wdata = '0, external_move_instruction_data = '0, flash_lock_key, program_store_control, flash_data;
    logic [15:0] external_move_instruction_addr = '0, flash_addr;
    logic [1:0] st, ctl;
    int err_total = 0, num_checks = 0, k;
    flash_lock_key_guard dut_u (.*);
    always #4 core_clk = ~core_clk;
    task chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task end_sim();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task rst();
        @(negedge core_clk);
        resetn = 1'b0;
        {key_wr, ctl_wr, external_move_instruction_write, flash_done} = '0;
        repeat (6) @(negedge core_clk);
        resetn = 1'b1;
        {st, ctl, bz, wr, er} = '0;
        chk(24'({flash_lock_key, program_store_control}), 24'h000000);
    endtask
    // one cycle of stimulus, the expected state follows the same priority
    task step(input logic en, kw, input logic [7:0] kd, input logic cw, mw, dn);
        @(negedge core_clk);
        {clk_en, key_wr, key_wdata, ctl_wr, ctl_wdata, external_move_instruction_write, flash_done} = {en, kw, kd, cw, kd, mw, dn};
        external_move_instruction_addr = 16'($urandom);
        external_move_instruction_data = 8'($urandom);
        if (en) begin
            {wr, er} = (mw && ctl[0] && st == 2'h2 && !bz) ? {!ctl[1], ctl[1]} : 2'b00;
            if (st == 2'h3) st = 2'h3;
            else if (mw && ctl[0] && st != 2'h2) st = 2'h3;
            else if (dn && bz) st = 2'h0;
            else if (kw) st = (st == 2'h0 && kd == 8'hA5) ? 2'h1 : (st == 2'h1 && kd == 8'hF1) ? 2'h2 : 2'h3;
            bz = (bz && !dn) || wr || er;
            if (cw) ctl = kd[1:0];
        end
        @(posedge core_clk);
        #1;
        chk(24'({flash_lock_key, program_store_control}), 24'({6'h00, st, 6'h00, ctl}));
        chk(24'({flash_wr_req, flash_erase_req, flash_busy}), 24'({wr, er, bz}));
        if (en && wr) chk({flash_addr, flash_data}, {external_move_instruction_addr, external_move_instruction_data});
        if (en && er) chk({flash_addr, flash_data}, {external_move_instruction_addr[15:9], 17'h00000});
    endtask
    initial begin
        k = $urandom(41);
        rst();
        step(1'b1, 1'b0, 8'hFF, 1'b1, 1'b0, 1'b0);
        step(1'b1, 1'b1, 8'hA5, 1'b0, 1'b0, 1'b0);
        step(1'b1, 1'b1, 8'hF1, 1'b0, 1'b0, 1'b0);
        step(1'b1, 1'b0, 8'h00, 1'b0, 1'b1, 1'b0);
        step(1'b1, 1'b0, 8'h00, 1'b0, 1'b1, 1'b0);
        step(1'b1, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1);
        step(1'b1, 1'b1, 8'hA5, 1'b0, 1'b0, 1'b0);
        step(1'b1, 1'b0, 8'h00, 1'b0, 1'b1, 1'b0);
        rst();
        step(1'b1, 1'b1, 8'h00, 1'b0, 1'b0, 1'b0);
        step(1'b1, 1'b1, 8'hA5, 1'b0, 1'b0, 1'b0);
        rst();
        step(1'b1, 1'b0, 8'h01, 1'b1, 1'b0, 1'b0);
        step(1'b1, 1'b1, 8'hA5, 1'b0, 1'b0, 1'b0);
        step(1'b1, 1'b1, 8'hF1, 1'b0, 1'b0, 1'b0);
        step(1'b1, 1'b0, 8'h00, 1'b0, 1'b1, 1'b0);
        step(1'b1, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1);
        step(1'b1, 1'b1, 8'hA5, 1'b0, 1'b0, 1'b0);
        step(1'b1, 1'b1, 8'h5A, 1'b0, 1'b0, 1'b0);
        repeat (80) begin
            rst();
            repeat (16) begin
                k = $urandom % 6;
                step($urandom % 8 != 0, k < 3, k == 0 ? 8'hA5 : k == 1 ? 8'hF1 : 8'($urandom), k == 3, k == 4, k == 5);
            end
        end
        end_sim();
    end
endmodule // flash_lock_key_guard_tb
`default_nettype wire
